//--- lic_defs.svh
// Constants for the LED select, init signalling, control port and ADC block
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH
`define LIC_CLK_MHZ       25
`define LIC_INIT_TIME_US  40
`define LIC_INIT_CYCLES   (`LIC_INIT_TIME_US * `LIC_CLK_MHZ)
`define LIC_SEG_TIME_US   100
`define LIC_SEG_CYCLES    (`LIC_SEG_TIME_US * `LIC_CLK_MHZ)
`define LIC_TARGET_ADDR   7'h1B
`define LIC_CFG_RESET     3'h7
`define LIC_LED_NONE      2'h0
`define LIC_LED_RED       2'h1
`define LIC_LED_GREEN     2'h2
`define LIC_LED_BLUE      2'h3
`define LIC_PWM_LAST      8'hFF
`endif

//--- lic_pkg.sv
// Types for the LED select and init signalling block
package lic_pkg;
  // Top phase: auto-init then running (Gray order)
  typedef enum logic [0:0] {LIC_INIT = 1'b0, LIC_RUN = 1'b1} lic_phase_t;
  // Whole state of the block
  typedef struct packed {
    lic_phase_t  phase;     // Init or run
    logic [15:0] initCnt;   // Auto-init time count
    logic        irqOut;    // Host interrupt level
    logic        irqOe;     // Host interrupt enable, low drives
    logic [1:0]  ledSel;    // Colour select code
    logic [15:0] segCnt;    // Colour slot time count
    logic        sclPrev;   // Previous clock line
    logic        sdaPrev;   // Previous data line
    logic        active;    // Inside a transfer
    logic [3:0]  bitCnt;    // Bits of current byte
    logic [7:0]  shift;     // Received bits
    logic        byteIdx;   // 0 address, 1 data
    logic        addrOk;    // Address matched
    logic        sdaOe;     // Data line enable, low drives
    logic [2:0]  cfg;       // Colour enable mask b,g,r
    logic [2:0]  sarBit;    // Bit under trial
    logic [7:0]  trial;     // Trial code
    logic [7:0]  pwmCnt;    // Charge duty counter
    logic        charge;    // Charge drive level
    logic [7:0]  code;      // Last conversion result
    logic        codeValid; // Result pulse
  } lic_state_t;
endpackage : lic_pkg

//--- lic_led_init_ctrl.sv
// LED colour sequencer, init interrupt, control port target and SAR ADC
`timescale 1ns/1ns
`default_nettype none
`include "lic_defs.svh"
module lic_led_init_ctrl
#(
  parameter int unsigned INIT_CYCLES = `LIC_INIT_CYCLES,
  parameter int unsigned SEG_CYCLES  = `LIC_SEG_CYCLES,
  parameter logic [6:0]  TARGET_ADDR = `LIC_TARGET_ADDR
)
(
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Host interrupt pin
  output logic            hostIrqOut,
  output logic            hostIrqOe,
  // Colour select pins
  output logic            led_color_select_bit0,
  output logic            led_color_select_bit1,
  // Control port pins
  input  wire logic       control_port_clock_line,
  input  wire logic       control_port_data_line_in,
  output logic            control_port_data_line_out,
  output logic            control_port_data_line_oe,
  // Temperature converter
  input  wire logic       comparator_result_in,
  output logic            ramp_charge_drive,
  output logic [7:0]      temperatureCode,
  output logic            temperatureValid
);

  // State register and its next value
  lic_pkg::lic_state_t s;
  lic_pkg::lic_state_t next_s;

  // Next enabled colour after cur, none when mask empty
  function automatic logic [1:0] nextColor(input logic [1:0] cur, input logic [2:0] mask);
    logic [1:0] c;
    logic [1:0] r;
    c = cur;
    r = `LIC_LED_NONE;
    for (int i = 0; i < 3; i++)
    begin
      c = (c == `LIC_LED_BLUE || c == `LIC_LED_NONE) ? `LIC_LED_RED : c + 2'h1;
      if (r == `LIC_LED_NONE && mask[c - 2'h1])
      begin
        r = c;
      end
    end
    return r;
  endfunction : nextColor

  // Next-state logic
  always_comb
  begin
    logic sclRise;
    logic sclFall;
    next_s = s;
    sclRise = control_port_clock_line && !s.sclPrev;
    sclFall = !control_port_clock_line && s.sclPrev;
    next_s.sclPrev = control_port_clock_line;
    next_s.sdaPrev = control_port_data_line_in;
    next_s.codeValid = 1'b0;
    case (s.phase)
      lic_pkg::LIC_INIT:
      begin
        next_s.irqOe = 1'b0;
        next_s.irqOut = 1'b0;
        next_s.ledSel = `LIC_LED_NONE;
        next_s.initCnt = s.initCnt + 16'h0001;
        if (s.initCnt == 16'(INIT_CYCLES - 1))
        begin
          next_s.phase = lic_pkg::LIC_RUN;
          next_s.irqOut = 1'b1;
        end
      end
      lic_pkg::LIC_RUN:
      begin
        // slot timer steps the colour itself
        next_s.segCnt = s.segCnt + 16'h0001;
        if (s.segCnt == 16'(SEG_CYCLES - 1) || s.ledSel == `LIC_LED_NONE
            || !s.cfg[s.ledSel - 2'h1])
        begin
          next_s.segCnt = 16'h0000;
          // code picks one colour or none
          next_s.ledSel = nextColor(s.ledSel, s.cfg);
        end
        // start and stop framing, start wins restart
        if (control_port_clock_line && s.sdaPrev && !control_port_data_line_in)
        begin
          next_s.active = 1'b1;
          next_s.bitCnt = 4'h0;
          next_s.byteIdx = 1'b0;
          next_s.sdaOe = 1'b1;
        end
        else if (control_port_clock_line && !s.sdaPrev && control_port_data_line_in)
        begin
          next_s.active = 1'b0;
          next_s.sdaOe = 1'b1;
        end
        else if (s.active && sclRise)
        begin
          if (s.bitCnt == 4'h8)
          begin
            // Acknowledge slot over, next byte follows
            next_s.bitCnt = 4'h0;
            next_s.byteIdx = 1'b1;
            next_s.active = s.addrOk;
          end
          else
          begin
            next_s.shift = {s.shift[6:0], control_port_data_line_in};
            next_s.bitCnt = s.bitCnt + 4'h1;
          end
        end
        else if (s.active && sclFall)
        begin
          if (s.bitCnt == 4'h8)
          begin
            // acknowledge own write address, store data
            if (!s.byteIdx)
            begin
              next_s.addrOk = (s.shift == {TARGET_ADDR, 1'b0});
              next_s.sdaOe = !(s.shift == {TARGET_ADDR, 1'b0});
            end
            else
            begin
              next_s.cfg = s.shift[2:0];
              next_s.sdaOe = 1'b0;
            end
          end
          else
          begin
            next_s.sdaOe = 1'b1;
          end
        end
        // charge duty follows the trial code
        next_s.pwmCnt = s.pwmCnt + 8'h01;
        next_s.charge = (s.pwmCnt < s.trial);
        if (s.pwmCnt == `LIC_PWM_LAST)
        begin
          // comparator low keeps the trial bit
          next_s.trial[s.sarBit] = !comparator_result_in;
          if (s.sarBit == 3'h0)
          begin
            next_s.code = {s.trial[7:1], !comparator_result_in};
            next_s.codeValid = 1'b1;
            next_s.sarBit = 3'h7;
            next_s.trial = 8'h80;
          end
          else
          begin
            next_s.sarBit = s.sarBit - 3'h1;
            next_s.trial[s.sarBit - 3'h1] = 1'b1;
          end
        end
      end
      default:
      begin
        next_s.phase = lic_pkg::LIC_INIT;
      end
    endcase
  end

  // State register; reset wins over enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '{phase: lic_pkg::LIC_INIT, irqOe: 1'b1, sdaOe: 1'b1, sclPrev: 1'b1,
             sdaPrev: 1'b1, cfg: `LIC_CFG_RESET, sarBit: 3'h7, trial: 8'h80,
             default: '0};
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops, except the data line output, which is tied low
  assign hostIrqOut = s.irqOut;
  assign hostIrqOe = s.irqOe;
  assign led_color_select_bit0 = s.ledSel[0];
  assign led_color_select_bit1 = s.ledSel[1];
  assign control_port_data_line_out = 1'b0;
  assign control_port_data_line_oe = s.sdaOe;
  assign ramp_charge_drive = s.charge;
  assign temperatureCode = s.code;
  assign temperatureValid = s.codeValid;

  // Step end and conversion end sequences
  sequence stepEnd;
    ce && !rst && s.phase == lic_pkg::LIC_RUN && s.pwmCnt == `LIC_PWM_LAST;
  endsequence
  sequence convEnd;
    stepEnd ##0 (s.sarBit == 3'h0);
  endsequence

  resetRelease_a: assert property (@(posedge clk) rst |=> hostIrqOe && s.ledSel == 2'h0)
    else $error("Reset did not release interrupt or clear select");
  initBusy_a: assert property (@(posedge clk) disable iff (rst)
    $past(!rst && ce) && s.phase == lic_pkg::LIC_INIT |-> !hostIrqOe && !hostIrqOut)
    else $error("Interrupt not low during init");
  initDone_a: assert property (@(posedge clk) disable iff (rst)
    $rose(s.phase == lic_pkg::LIC_RUN) |-> hostIrqOut && !hostIrqOe)
    else $error("Interrupt not high at init done");
  initDark_a: assert property (@(posedge clk) disable iff (rst)
    s.phase == lic_pkg::LIC_INIT |-> !led_color_select_bit0 && !led_color_select_bit1)
    else $error("Select not low during init");
  colorEnabled_a: assert property (@(posedge clk) disable iff (rst)
    $past(ce) && s.ledSel != 2'h0 && $stable(s.cfg) |-> s.cfg[s.ledSel - 2'h1])
    else $error("Select shows a disabled colour");
  maskEmpty_a: assert property (@(posedge clk) disable iff (rst)
    ce && s.phase == lic_pkg::LIC_RUN && s.cfg == 3'h0 |=> s.ledSel == 2'h0)
    else $error("Select active with empty mask");
  ackTiming_a: assert property (@(posedge clk) disable iff (rst)
    $fell(control_port_data_line_oe) |-> !control_port_clock_line)
    else $error("Data line driven while clock high");
  sarResult_a: assert property (@(posedge clk) disable iff (rst)
    convEnd |=> temperatureValid && temperatureCode[0] == !$past(comparator_result_in))
    else $error("Conversion result wrong");
  sarRestart_a: assert property (@(posedge clk) disable iff (rst)
    convEnd |=> s.trial == 8'h80 && s.sarBit == 3'h7)
    else $error("Conversion did not restart");

endmodule : lic_led_init_ctrl
`default_nettype wire

//--- lic_host_model.sv
// Host controller and thermistor comparator facing the block
`timescale 1ns/1ns
`default_nettype none
module lic_host_model
#(
  parameter logic [7:0] THRESHOLD = 8'h5A  // Thermistor level in code units
)
(
  // Clock
  input  wire logic clk,
  // Pins seen from the far side
  input  wire logic chargeIn,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow,
  output logic      cmpOut
);
  logic [8:0] runCnt;   // Length of the current charge burst
  logic [8:0] lastRun;  // Length of the last finished burst
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
    runCnt = 9'h000;
    lastRun = 9'h000;
  end
  // Burst length stands in for the filtered ramp voltage
  always @(posedge clk)
  begin
    if (chargeIn)
      runCnt <= runCnt + 9'h001;
    else if (runCnt != 9'h000)
    begin
      lastRun <= runCnt;
      runCnt <= 9'h000;
    end
  end
  assign cmpOut = (lastRun > {1'b0, THRESHOLD});
  // Line edges stay four cycles apart, well above the minimum spacing
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaLow = !b[i];
      half();
      scl = 1'b1;
      half();
      scl = 1'b0;
      half();
    end
    sdaLow = 1'b0;
    half();
    scl = 1'b1;
    half();
    ack = !sdaLine;
    scl = 1'b0;
    half();
  endtask : send_byte
  // start, address plus write, one data byte, stop
  task automatic write_frame(input logic [6:0] addr, input logic [7:0] data,
                             output logic ackA, output logic ackD);
    sdaLow = 1'b1;
    half();
    scl = 1'b0;
    half();
    send_byte({addr, 1'b0}, ackA);
    send_byte(data, ackD);
    sdaLow = 1'b1;
    half();
    scl = 1'b1;
    half();
    sdaLow = 1'b0;
    half();
  endtask : write_frame
endmodule : lic_host_model
`default_nettype wire

//--- lic_led_init_ctrl_tb_top.sv
// Self-checking bench for the LED select and init signalling block
`timescale 1ns/1ns
`default_nettype none
module lic_led_init_ctrl_tb_top;
  localparam int INIT = 8;  // Short auto-init
  localparam int SEG  = 4;  // Short colour slot
  logic clk, rst, ce;       // Clock, reset, enable
  logic irqOut, irqOe;      // Host interrupt pin
  logic sel0, sel1;         // Colour select pins
  logic scl, sdaLow, sdaOut, sdaOe, sdaLine; // Control port lines
  logic cmp, charge, valid; // Converter pins
  logic [7:0] code;         // Conversion result
  logic ackA, ackD;         // Acks seen by the host
  int failCount = 0;        // Mismatches
  int checkCount = 0;       // Comparisons
  // Open drain data line with pull-up
  assign sdaLine = !(sdaLow || (!sdaOe && !sdaOut));
  lic_led_init_ctrl #(.INIT_CYCLES(INIT), .SEG_CYCLES(SEG)) i_lic_led_init_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .hostIrqOut(irqOut), .hostIrqOe(irqOe),
    .led_color_select_bit0(sel0), .led_color_select_bit1(sel1),
    .control_port_clock_line(scl), .control_port_data_line_in(sdaLine),
    .control_port_data_line_out(sdaOut), .control_port_data_line_oe(sdaOe),
    .comparator_result_in(cmp), .ramp_charge_drive(charge),
    .temperatureCode(code), .temperatureValid(valid));
  lic_host_model i_lic_host_model (.clk(clk), .chargeIn(charge), .sdaLine(sdaLine),
    .scl(scl), .sdaLow(sdaLow), .cmpOut(cmp));
  // Clock at 25 MHz
  initial
  begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      failCount++;
    end
  endtask : check
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Reset held: pin released, colours off
  task automatic reset_phase();
    rst = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h00, irqOe}, 8'h01);
    check({6'h00, sel1, sel0}, 8'h00);
    rst = 1'b0;
  endtask : reset_phase
  // Init busy then done, colours off throughout
  task automatic init_phase();
    int n;
    n = 0;
    @(negedge clk);
    while (irqOut !== 1'b1 && n < INIT + 8)
    begin
      check({7'h00, irqOe}, 8'h00);
      check({6'h00, sel1, sel0}, 8'h00);
      @(negedge clk);
      n++;
    end
    check({7'h00, irqOut}, 8'h01);
    // Bound used up: the mismatch is counted, report now
    if (irqOut !== 1'b1)
    begin
      conclude();
    end
  endtask : init_phase
  // Write a mask, then only the expected colours may appear, both of them
  task automatic colours(input logic [7:0] mask, input logic [1:0] a, input logic [1:0] b);
    logic sa, sb;
    sa = 1'b0;
    sb = 1'b0;
    i_lic_host_model.write_frame(7'h1B, mask, ackA, ackD);
    check({6'h00, ackA, ackD}, 8'h03);
    repeat (SEG + 2) @(negedge clk);
    repeat (8 * SEG)
    begin
      check({7'h00, {sel1, sel0} == a || {sel1, sel0} == b}, 8'h01);
      sa |= ({sel1, sel0} == a);
      sb |= ({sel1, sel0} == b);
      @(negedge clk);
    end
    check({6'h00, sa, sb}, 8'h03);
  endtask : colours
  // Wrong address gets no ack and leaves the colour alone
  task automatic bad_address();
    i_lic_host_model.write_frame(7'h1C, 8'h04, ackA, ackD);
    check({6'h00, ackA, ackD}, 8'h00);
    check({6'h00, sel1, sel0}, 8'h02);
  endtask : bad_address
  // Converter settles on the thermistor level
  task automatic conversion();
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    // Bound used up counts as a mismatch and ends the run
    if (valid !== 1'b1)
    begin
      failCount++;
      conclude();
    end
    else
    begin
      check(code, 8'h5A);
    end
  endtask : conversion
  // Enable low must hold charge drive and colour still for a whole step
  task automatic freeze();
    logic       c0;
    logic [1:0] s0;
    c0 = charge;
    s0 = {sel1, sel0};
    ce = 1'b0;
    // Longer than one charge window, so a running duty counter would show
    repeat (300)
    begin
      @(negedge clk);
      check({7'h00, charge}, {7'h00, c0});
      check({6'h00, sel1, sel0}, {6'h00, s0});
    end
    ce = 1'b1;
  endtask : freeze
  initial
  begin
    ce = 1'b1;
    reset_phase();
    init_phase();
    colours(8'h01, 2'b01, 2'b01);
    colours(8'h04, 2'b11, 2'b11);
    colours(8'h03, 2'b01, 2'b10);
    colours(8'h00, 2'b00, 2'b00);
    colours(8'h02, 2'b10, 2'b10);
    bad_address();
    conversion();
    freeze();
    reset_phase();
    init_phase();
    conclude();
  end
endmodule : lic_led_init_ctrl_tb_top
`default_nettype wire
